// File: clock_output_matrix_control.sv
// Control pins, serial register bus and six-output switch matrix
`timescale 1ns/1ps
`include "clock_matrix_defines.svh"
module clock_output_matrix_control
	import clock_matrix_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	// Multi-function pins
	input wire logic multi_function_pin_a,
	input wire logic multi_function_pin_b,
	// Clock sources, sampled on clk_sys
	input wire logic first_clock_input,
	input wire logic second_clock_input,
	input wire logic [3:0] pll_clock,
	// Serial management bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Clock outputs
	output logic [5:0] clock_output,
	output logic [5:0] clock_output_oe_n,
	output logic [11:0] edge_rate_control,
	// Power and path control
	output power_ctl_type power_ctl
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Register windows are contiguous, so one compare pair and an
	// offset from the window base decode every per-output byte
	function automatic logic in_range(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [2:0] slot(input logic [7:0] a,
		input logic [7:0] lo);
		slot = 3'(a - lo);
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	pin_cfg_type pin_cfg_r;
	out_cfg_type out_cfg_r [0:5];
	logic [6:0] div_r [0:5];
	logic [7:0] route_r [0:5];

	// ------------------------------------------------------------
	// Pin function decode
	// ------------------------------------------------------------
	// Both high mode bits set turn the pins into address bits; then
	// neither pin controls outputs, clock select or power-down.
	// A single high mode bit on pin b alone leaves pin b without a
	// control job, so only a pin a power-down can 3-state the outputs.
	wire addr_mode = pin_cfg_r.pin_a_mode_bit_high &
		pin_cfg_r.pin_b_mode_bit_high;
	wire [1:0] pin_a_mode = {pin_cfg_r.pin_a_mode_bit_high,
		pin_cfg_r.pin_a_mode_bit_low};
	wire pin_a_ctl = !pin_cfg_r.pin_a_mode_bit_high;
	wire pin_b_ctl = !pin_cfg_r.pin_b_mode_bit_high;
	wire device_pd = pin_a_ctl && pin_a_mode == 2'b00 &&
		!multi_function_pin_a;
	wire bypass = pin_a_ctl && pin_a_mode == 2'b01 &&
		!multi_function_pin_a;
	wire clk_sel_mode = pin_a_mode == 2'b10 && pin_b_ctl;
	wire in_sel = clk_sel_mode & multi_function_pin_a;
	wire sel_input = in_sel ? second_clock_input : first_clock_input;
	wire out_ctl_low = pin_b_ctl && !multi_function_pin_b;
	wire out_tri = out_ctl_low & pin_cfg_r.pin_b_mode_bit_low;
	wire out_static = out_ctl_low & !pin_cfg_r.pin_b_mode_bit_low;

	// Power-down and 3-state share one output code; power-down also
	// shows separately on power_ctl, which keeps the priority order
	out_mode_type global_mode;
	assign global_mode = (device_pd || out_tri) ? OUT_TRISTATE :
		out_static ? OUT_STATIC : OUT_ACTIVE;

	// ------------------------------------------------------------
	// Switch A, post-dividers, switch B
	// ------------------------------------------------------------
	// Sources are sampled levels, so a divider only sees edges that
	// are slower than half the system clock
	logic [5:0] src_lvl;
	logic [5:0] src_prev_r;
	logic [6:0] cnt_r [0:5];
	logic [5:0] div_q_r;
	logic [5:0] out_val;
	logic [5:0] out_oe_n_val;

	genvar g;
	generate
		for (g = 0; g < `OUT_COUNT; g++) begin : g_path
			wire [2:0] sel_a = route_r[g][`ROUTE_A_LSB +: 3];
			wire [2:0] sel_b = route_r[g][`ROUTE_B_LSB +: 3];
			wire [6:0] div_eff = (div_r[g] == 7'h00) ? 7'h01 : div_r[g];
			wire src_edge = src_lvl[g] ^ src_prev_r[g];
			wire wrap = (cnt_r[g] + 7'h01) >= div_eff;
			wire routed = (sel_b < 3'(`OUT_COUNT)) ?
				div_q_r[sel_b] : 1'b0;
			wire active_val = bypass ? sel_input : routed;
			wire enabled = out_cfg_r[g].enable;

			assign src_lvl[g] = (sel_a == `SRC_INPUT || bypass) ?
				sel_input : (sel_a < 3'(`PLL_COUNT)) ?
				pll_clock[sel_a[1:0]] : 1'b0;

			assign out_oe_n_val[g] = global_mode == OUT_TRISTATE;
			assign out_val[g] = (global_mode == OUT_ACTIVE && enabled) ?
				active_val ^ out_cfg_r[g].invert :
				out_cfg_r[g].invert &
				(global_mode != OUT_TRISTATE);

			// Counting both source edges gives 50 percent duty for odd N
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					src_prev_r[g] <= 1'b0;
					cnt_r[g] <= 7'h00;
					div_q_r[g] <= 1'b0;
				end else if (clk_en) begin
					src_prev_r[g] <= src_lvl[g];
					if (src_edge && wrap) begin
						cnt_r[g] <= 7'h00;
						div_q_r[g] <= !div_q_r[g];
					end else if (src_edge) begin
						cnt_r[g] <= cnt_r[g] + 7'h01;
					end
				end
			end
		end
	endgenerate

	// A new divide value takes effect at once; no glitch guard
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clock_output <= 6'h00;
			clock_output_oe_n <= 6'h3F;
			power_ctl <= '0;
		end else if (clk_en) begin
			clock_output <= out_val;
			clock_output_oe_n <= out_oe_n_val;
			power_ctl <= {device_pd | bypass, device_pd, bypass, in_sel};
		end
	end

	always_comb begin
		for (int i = 0; i < `OUT_COUNT; i++) begin
			edge_rate_control[2*i +: 2] =
				out_cfg_r[i].edge_rate_control;
		end
	end

	// ------------------------------------------------------------
	// Serial bus slave
	// ------------------------------------------------------------
	smb_state_type state_r;
	logic scl_prev_r;
	logic sda_prev_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] cmd_r;
	logic rd_r;

	// Address mode keeps the upper base bits and takes the low bits
	// from the pins, so up to four parts can share one bus
	wire [6:0] base_addr = `SMB_BASE_ADDR;
	wire [6:0] my_addr = addr_mode ?
		{base_addr[6:`ADDR_PIN_BITS], multi_function_pin_b,
		multi_function_pin_a} : base_addr;
	// Bus lines are sampled on clk_sys, so each bus clock phase must
	// last at least three system clocks for edges to be seen
	wire scl_rise = scl_in && !scl_prev_r;
	wire scl_fall = !scl_in && scl_prev_r;
	wire start_c = scl_in && scl_prev_r && sda_prev_r && !sda_in;
	wire stop_c = scl_in && scl_prev_r && !sda_prev_r && sda_in;
	wire byte_done = bit_cnt_r == `BITS_PER_BYTE;
	wire addr_hit = shift_r[7:1] == my_addr;
	wire wr_en = state_r == SMB_WDATA && scl_fall && byte_done;

	logic [7:0] rd_data;
	assign rd_data =
		(cmd_r == `OFS_PIN_CFG) ? pin_cfg_r :
		in_range(cmd_r, `OFS_OUT_CFG_FIRST, `OFS_OUT_CFG_LAST) ?
		out_cfg_r[slot(cmd_r, `OFS_OUT_CFG_FIRST)] :
		in_range(cmd_r, `OFS_DIV_FIRST, `OFS_DIV_LAST) ?
		{1'b0, div_r[slot(cmd_r, `OFS_DIV_FIRST)]} :
		in_range(cmd_r, `OFS_ROUTE_FIRST, `OFS_ROUTE_LAST) ?
		route_r[slot(cmd_r, `OFS_ROUTE_FIRST)] :
		(cmd_r == `OFS_STATUS) ?
		{2'h0, global_mode, power_ctl} : 8'h00;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else if (clk_en) begin
			scl_prev_r <= scl_in;
			sda_prev_r <= sda_in;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= SMB_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			rd_r <= 1'b0;
			sda_out <= 1'b1;
			sda_oe_n <= 1'b1;
		end else if (clk_en) begin
			if (start_c) begin
				state_r <= SMB_ADDR;
				bit_cnt_r <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (stop_c) begin
				state_r <= SMB_IDLE;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (state_r)
					SMB_ADDR, SMB_CMD, SMB_WDATA: begin
						shift_r <= {shift_r[6:0], sda_in};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					SMB_RACK: begin
						state_r <= sda_in ? SMB_SKIP : SMB_RDATA;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state_r)
					SMB_ADDR: begin
						if (byte_done && addr_hit) begin
							rd_r <= shift_r[0];
							state_r <= SMB_ACK_ADDR;
							sda_out <= 1'b0;
							sda_oe_n <= 1'b0;
						end else if (byte_done) begin
							state_r <= SMB_SKIP;
						end
					end
					SMB_CMD, SMB_WDATA: begin
						if (byte_done) begin
							if (state_r == SMB_CMD) begin
								cmd_r <= shift_r;
							end
							state_r <= (state_r == SMB_CMD) ?
								SMB_ACK_CMD : SMB_ACK_W;
							sda_out <= 1'b0;
							sda_oe_n <= 1'b0;
						end
					end
					SMB_ACK_ADDR, SMB_ACK_CMD, SMB_ACK_W: begin
						bit_cnt_r <= 4'h0;
						sda_oe_n <= 1'b1;
						state_r <= (state_r == SMB_ACK_CMD ||
							state_r == SMB_ACK_W) ? SMB_WDATA :
							rd_r ? SMB_RDATA : SMB_CMD;
						if (state_r == SMB_ACK_ADDR && rd_r) begin
							shift_r <= {rd_data[6:0], 1'b0};
							sda_out <= rd_data[7];
							sda_oe_n <= rd_data[7];
							bit_cnt_r <= 4'h1;
						end
					end
					SMB_RDATA: begin
						// Open drain: only a zero bit is driven
						if (byte_done) begin
							sda_oe_n <= 1'b1;
							state_r <= SMB_RACK;
							bit_cnt_r <= 4'h0;
						end else begin
							sda_out <= shift_r[7];
							sda_oe_n <= shift_r[7];
							shift_r <= {shift_r[6:0], 1'b0};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Register writes; bytes read after the first in one transfer are 0x00
	// ------------------------------------------------------------
	// No auto-increment: every data byte of one transfer lands in
	// the register named by the command byte.
	// Unmapped commands are acked but change nothing.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_cfg_r <= `RST_PIN_CFG;
			for (int i = 0; i < `OUT_COUNT; i++) begin
				out_cfg_r[i] <= `RST_OUT_CFG;
				div_r[i] <= `RST_DIV;
				route_r[i] <= `RST_ROUTE | 8'(i << `ROUTE_B_LSB) |
					8'(`SRC_INPUT);
			end
		end else if (clk_en && wr_en) begin
			if (cmd_r == `OFS_PIN_CFG) begin
				pin_cfg_r <= {4'h0, shift_r[3:0]};
			end
			if (in_range(cmd_r, `OFS_OUT_CFG_FIRST, `OFS_OUT_CFG_LAST)) begin
				out_cfg_r[slot(cmd_r, `OFS_OUT_CFG_FIRST)] <=
					shift_r;
			end
			if (in_range(cmd_r, `OFS_DIV_FIRST, `OFS_DIV_LAST)) begin
				div_r[slot(cmd_r, `OFS_DIV_FIRST)] <= shift_r[6:0];
			end
			if (in_range(cmd_r, `OFS_ROUTE_FIRST, `OFS_ROUTE_LAST)) begin
				route_r[slot(cmd_r, `OFS_ROUTE_FIRST)] <= shift_r;
			end
		end
	end

endmodule

// File: clock_matrix_defines.svh
// Register offsets, field positions, reset values and bus constants
`ifndef CLOCK_MATRIX_DEFINES_SVH
`define CLOCK_MATRIX_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte command codes)
// ----------------------------------------------------------------
`define OFS_PIN_CFG 8'h0A
`define OFS_OUT_CFG_FIRST 8'h13
`define OFS_OUT_CFG_LAST 8'h18
`define OFS_DIV_FIRST 8'h20
`define OFS_DIV_LAST 8'h25
`define OFS_ROUTE_FIRST 8'h28
`define OFS_ROUTE_LAST 8'h2D
`define OFS_STATUS 8'h30

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PIN_CFG 8'h00
`define RST_OUT_CFG 8'h08
`define RST_DIV 7'h01
`define RST_ROUTE 8'h00

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define ROUTE_A_LSB 0
`define ROUTE_B_LSB 4
`define SRC_INPUT 3'h4
`define PLL_COUNT 4
`define OUT_COUNT 6
`define ADDR_PIN_BITS 2
// Arbitrary neutral bus address
`define SMB_BASE_ADDR 7'h68
`define BITS_PER_BYTE 4'h8

`endif

// File: clock_matrix_pkg.sv
// Types shared by the clock output matrix control logic
package clock_matrix_pkg;

	typedef struct packed {
		logic reserved_7;
		logic invert;
		logic [1:0] edge_rate_control;
		logic enable;
		logic [2:0] reserved_2_0;
	} out_cfg_type;

	typedef struct packed {
		logic [3:0] reserved_7_4;
		logic pin_b_mode_bit_high;
		logic pin_b_mode_bit_low;
		logic pin_a_mode_bit_high;
		logic pin_a_mode_bit_low;
	} pin_cfg_type;

	typedef struct packed {
		logic pll_power_down;
		logic input_power_down;
		logic pll_bypass;
		logic clock_input_select;
	} power_ctl_type;

	typedef enum logic [1:0] {
		OUT_ACTIVE,
		OUT_STATIC,
		OUT_TRISTATE
	} out_mode_type;

	typedef enum logic [3:0] {
		SMB_IDLE,
		SMB_ADDR,
		SMB_ACK_ADDR,
		SMB_CMD,
		SMB_ACK_CMD,
		SMB_WDATA,
		SMB_ACK_W,
		SMB_RDATA,
		SMB_RACK,
		SMB_SKIP
	} smb_state_type;

endpackage

// File: clock_sink.sv
// Downstream receiver that measures high pulses on output 0
`timescale 1ns/1ps
module clock_sink (
	// Clock
	input wire logic clk_sys,
	// Clock outputs seen at the pins
	input wire logic [5:0] clock_output,
	input wire logic [5:0] clock_output_oe_n,
	// Length of the last complete high pulse
	output logic [7:0] high_len
);
	logic [7:0] run = 8'h00;
	initial high_len = 8'h00;
	// A 3-stated line carries no clock, so it ends the pulse
	always @(posedge clk_sys) begin
		if (!clock_output_oe_n[0] && clock_output[0]) begin
			run <= run + 8'h01;
		end else begin
			if (run != 8'h00) high_len <= run;
			run <= 8'h00;
		end
	end
endmodule

// File: clock_output_matrix_chk.sv
// Port assertions for the clock output matrix control
`timescale 1ns/1ps
module clock_output_matrix_chk
	import clock_matrix_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Observed ports
	input wire logic multi_function_pin_a,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic [5:0] clock_output_oe_n,
	input wire logic [11:0] edge_rate_control,
	input wire power_ctl_type power_ctl
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sda_drive_a: assert property (!sda_oe_n |-> !sda_out)
		else $error("bus line driven high");
	ack_phase_a: assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in))
		else $error("bus line taken while clock high");
	slew_update_a: assert property (!$stable(edge_rate_control) |-> !scl_in)
		else $error("edge rate changed outside a bus write");
	oe_group_a: assert property (clock_output_oe_n == 6'h00 || clock_output_oe_n == 6'h3F)
		else $error("outputs split between 3-state and driven");
	pd_tristate_a: assert property (power_ctl.input_power_down |-> &clock_output_oe_n)
		else $error("outputs driven during power-down");
	input_pd_a: assert property (power_ctl.input_power_down |-> power_ctl.pll_power_down && !power_ctl.pll_bypass)
		else $error("power-down incomplete");
	bypass_pd_a: assert property (power_ctl.pll_bypass |-> power_ctl.pll_power_down && !power_ctl.input_power_down)
		else $error("bypass without PLL power-down");
	clk_sel_a: assert property (power_ctl.clock_input_select |-> $past(multi_function_pin_a) && !power_ctl.pll_power_down)
		else $error("second input chosen with pin low");
	cover property (power_ctl.input_power_down);
	cover property (power_ctl.pll_bypass);
	cover property (power_ctl.clock_input_select);
endmodule
bind clock_output_matrix_control clock_output_matrix_chk chk (.clk_sys, .rstn,
	.multi_function_pin_a, .scl_in, .sda_out, .sda_oe_n, .clock_output_oe_n,
	.edge_rate_control, .power_ctl);

// File: tb_clock_output_matrix_control.sv
// Testbench for the clock output matrix control
`timescale 1ns/1ps
module tb_clock_output_matrix_control import clock_matrix_pkg::*; ;
	logic clk_sys = 1'b0, rstn = 1'b0, scl_in = 1'b1, sda_drv = 1'b1;
	logic multi_function_pin_a = 1'b1, multi_function_pin_b = 1'b1;
	logic first_clock_input = 1'b0, second_clock_input = 1'b0;
	logic [3:0] pll_clock = 4'h0;
	logic sda_out, sda_oe_n, nak;
	logic [5:0] clock_output, clock_output_oe_n;
	logic [11:0] edge_rate_control;
	power_ctl_type power_ctl;
	logic [7:0] high_len, q;
	int errors = 0, total_checks = 0, cyc = 0;
	// Pull-up on the bus line: low wins
	wire sda_in = sda_drv & (sda_oe_n | sda_out);
	// Pin a | pin b | 3-state | power_ctl, below the pin cfg nibble
	logic [11:0] rows [10] = '{12'h0C0, 12'h080, 12'h4A0, 12'h06C, 12'h10A,
		12'h52A, 12'h14A, 12'h2C1, 12'h240, 12'h6A1};

	clock_output_matrix_control uut (.clk_sys, .rstn, .clk_en(1'b1),
		.multi_function_pin_a, .multi_function_pin_b, .first_clock_input,
		.second_clock_input, .pll_clock, .scl_in, .sda_in, .sda_out,
		.sda_oe_n, .clock_output, .clock_output_oe_n, .edge_rate_control,
		.power_ctl);
	clock_sink sink (.clk_sys, .clock_output, .clock_output_oe_n, .high_len);

	always #20 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		second_clock_input <= ~second_clock_input;
		if (cyc[0]) begin
			first_clock_input <= ~first_clock_input;
			pll_clock <= pll_clock + 4'h1;
		end
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			results;
		end
	end

	task chk(input logic [11:0] s, e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Each bus phase lasts four system clocks, above the three required
	task ph;
		repeat (4) @(negedge clk_sys);
	endtask
	task bt(input logic b, output logic r);
		sda_drv = b;
		ph;
		scl_in = 1'b1;
		ph;
		r = sda_in;
		scl_in = 1'b0;
		ph;
	endtask
	task by(input logic [7:0] d, output logic [7:0] r, output logic n);
		for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
		bt(1'b1, n);
	endtask
	task st;
		sda_drv = 1'b1;
		ph;
		scl_in = 1'b1;
		ph;
		sda_drv = 1'b0;
		ph;
		scl_in = 1'b0;
		ph;
	endtask
	task sp;
		sda_drv = 1'b0;
		ph;
		scl_in = 1'b1;
		ph;
		sda_drv = 1'b1;
		ph;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] c, d);
		logic n1, n2, n3;
		st;
		by({a, 1'b0}, q, n1);
		by(c, q, n2);
		by(d, q, n3);
		sp;
		nak = n1 | n2 | n3;
	endtask
	// Master NACK on the data byte ends the read
	task rd(input logic [6:0] a, input logic [7:0] c);
		logic n;
		st;
		by({a, 1'b0}, q, n);
		by(c, q, n);
		st;
		by({a, 1'b1}, q, n);
		by(8'hFF, q, n);
		sp;
	endtask

	initial begin
		repeat (4) @(negedge clk_sys);
		chk(clock_output_oe_n, 12'h03F);
		chk(power_ctl, 12'h000);
		rstn = 1'b1;
		rd(7'h68, 8'h13);
		chk(q, 12'h008);
		chk(edge_rate_control, 12'h000);
		wr(7'h68, 8'h40, 8'h5A);
		rd(7'h68, 8'h40);
		chk(q, 12'h000);
		$display("reset and bus test done");
		foreach (rows[i]) begin
			wr(7'h68, 8'h0A, {4'h0, rows[i][11:8]});
			multi_function_pin_a = rows[i][7];
			multi_function_pin_b = rows[i][6];
			repeat (3) @(negedge clk_sys);
			chk(clock_output_oe_n, {6'h00, {6{rows[i][5]}}});
			chk(power_ctl, rows[i][3:0]);
			if (!rows[i][5] && !rows[i][6])
				chk(clock_output, 12'h000);
		end
		$display("pin mode table done");
		multi_function_pin_a = 1'b1;
		multi_function_pin_b = 1'b0;
		wr(7'h68, 8'h0A, 8'h0A);
		chk(nak, 12'h000);
		wr(7'h68, 8'h0A, 8'h00);
		chk(nak, 12'h001);
		wr(7'h69, 8'h0A, 8'h00);
		chk(nak, 12'h000);
		multi_function_pin_b = 1'b1;
		$display("address test done");
		wr(7'h68, 8'h20, 8'h03);
		wr(7'h68, 8'h28, 8'h04);
		wr(7'h68, 8'h29, 8'h04);
		wr(7'h68, 8'h14, 8'h68);
		wr(7'h68, 8'h15, 8'h00);
		chk(edge_rate_control, 12'h008);
		repeat (40) @(negedge clk_sys);
		chk(high_len, 12'h006);
		for (int i = 0; i < 24; i++) begin
			@(negedge clk_sys);
			chk(clock_output[1], !clock_output[0]);
			chk(clock_output[2], 12'h000);
		end
		multi_function_pin_b = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(clock_output, 12'h002);
		$display("matrix test done");
		results;
	end
endmodule
